// File: cor_consts.svh
/*
 * Offsets, field positions, reset values and serial-bus constants of the
 * clock output control register bank.
 * Assumes it is included by bare name wherever these values are used.
 */
`ifndef COR_CONSTS_SVH
`define COR_CONSTS_SVH

// ==================================================
// register offsets
`define COR_OFS_OUTPUT_ENABLE_A 7'h00
`define COR_OFS_OUTPUT_ENABLE_B 7'h01
`define COR_OFS_SPREAD_MODE_CONTROL 7'h02
`define COR_OFS_SPREAD_SELECT_A 7'h03
`define COR_OFS_SPREAD_SELECT_B 7'h04
`define COR_OFS_FREQUENCY_SELECT_A 7'h05
`define COR_NUM_REGS 8'h06

// ==================================================
// power-up values
`define COR_RST_OUTPUT_ENABLE_A 8'hFF
`define COR_RST_OUTPUT_ENABLE_B 8'hFF
`define COR_RST_SPREAD_MODE_CONTROL 8'h04
`define COR_RST_SPREAD_SELECT_A 8'h00
`define COR_RST_SPREAD_SELECT_B 8'h00
`define COR_RST_FREQUENCY_SELECT_A 8'h00

// ==================================================
// spread_mode_control fields
`define COR_BIT_MODE_FIELD_HIGH 7
`define COR_BIT_MODE_FIELD_LOW 6
`define COR_BIT_PUMP_SETTING_HIGH 5
`define COR_BIT_DRIVE_STRENGTH 4
`define COR_BIT_FREQ_SOURCE_SELECT 3
`define COR_BIT_MASTER_SPREAD_ENABLE 2
`define COR_BIT_SPREAD_DEPTH_HIGH 1
`define COR_BIT_SPREAD_DEPTH_LOW 0
// spread_select_b
`define COR_BIT_PUMP_SETTING_LOW 0

// mode field codes
`define COR_MODE_TEST_OUTPUT 2'h1
`define COR_MODE_POWERDOWN_RESET 2'h2

// ==================================================
// serial bus
// arbitrary bus address, not tied to any strap
`define COR_DEV_ADDR 7'h2A
`define COR_CMD_BLOCK 8'h00
`define COR_BITS_PER_BYTE 4'h8

`endif

// File: cor_pkg.sv
/*
 * Types shared by the clock output control register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cor_pkg;

	// ==================================================
	// serial protocol states, gray along the usual path
	typedef enum logic [3:0] {
		cor_st_idle = 4'h0,
		cor_st_addr = 4'h1,
		cor_st_addr_ack = 4'h3,
		cor_st_cmd = 4'h2,
		cor_st_cmd_ack = 4'h6,
		cor_st_count = 4'h7,
		cor_st_count_ack = 4'h5,
		cor_st_wdata = 4'h4,
		cor_st_wdata_ack = 4'hC,
		cor_st_rdata = 4'hD,
		cor_st_rdata_ack = 4'hF
	} cor_state_type;

endpackage

// File: cor_sync.sv
/*
 * Two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level or a clock slow against mclk.
 */
`timescale 1ns/1ps

module cor_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic mclk, // sampling clock
	input wire logic reset, // synchronous, active high
	input wire logic [WIDTH-1:0] async_in, // levels from outside the domain
	output logic [WIDTH-1:0] sync_out // synchronised levels
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge mclk) begin
		if (reset) begin
			// idle level of each pin, so no false edge follows reset
			meta_reg <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// File: cor_hold.sv
/*
 * Holding stage that lets a control value reach the clock path only at
 * a safe output-cycle boundary.
 * Assumes boundary is a one-cycle pulse in the mclk domain.
 */
`timescale 1ns/1ps

module cor_hold #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic mclk, // clock
	input wire logic reset, // synchronous, active high
	input wire logic boundary, // pulse at a safe output edge
	input wire logic [WIDTH-1:0] staged, // value from the register bank
	output logic [WIDTH-1:0] applied // value seen by the clock path
);

	// switching only at the boundary keeps outputs free of runts
	always_ff @(posedge mclk) begin
		if (reset) begin
			applied <= RESET_VAL;
		end else if (boundary) begin
			applied <= staged; // RL11
		end
	end

endmodule

// File: cor_regs.sv
/*
 * Clock output control register bank with its two-wire serial slave.
 * Assumes scl, sda_in, the strap and the boundary pin are asynchronous to
 * mclk and much slower; sda is open drain, pulled up outside.
 */
// Operation
// RL1 - first enable byte gates group-zero outputs, bit 7 is output zero, all set
// RL2 - second enable byte gates groups one to three and crystal output, all set
// RL3 - enable one drives the output, zero puts it in high impedance
// RL4 - mode field bits 7:6: 01 test output, 10 power-down reset, else normal
// RL5 - pump setting: high bit in spread control, low bit in spread select b
// RL6 - bit 4 selects output drive strength, low after power-up
// RL7 - bit 3 chooses strap or register frequency source
// RL8 - master should program frequency bits before choosing register source
// RL9 - bit 2 is master spread enable, set after power-up
// RL10 - bits 1:0 select spread depth
// RL11 - spread on or off must not glitch outputs
// RL12 - first spread byte marks group-zero outputs fed from spreading pll
// RL13 - second spread byte marks groups one to three outputs for spread
// RL14 - each spread bit set applies modulation to its output
// RL15 - first frequency byte selects 33 or 66 MHz per group-zero output
// RL16 - command with top bit set is byte access at low seven bit offset
// RL17 - command zero is block access from offset zero with byte count
// RL18 - registers keep power-up value until written, reads return contents
// RL19 - a written byte takes effect only after it is acknowledged
`timescale 1ns/1ps
`include "cor_consts.svh"

module cor_regs #(
	parameter logic [6:0] DEV_ADDR = `COR_DEV_ADDR // arbitrary bus address
) (
	input wire logic mclk, // 250 MHz clock
	input wire logic reset, // synchronous, active high
	input wire logic scl, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive value, always low
	output logic sda_oe, // high while pulling sda low
	input wire logic group_freq_strap, // group-zero frequency strap
	input wire logic spread_boundary, // safe-edge marker from clock path
	output logic [7:0] grp_zero_oe, // output enables, bit 7 = output zero
	output logic [7:0] grp_mixed_oe, // g1 out0-3, g2 out0-1, g3, crystal
	output logic test_output_mode, // mode field selects test output
	output logic powerdown_reset_mode, // mode field selects power-down
	output logic [1:0] pump_setting, // charge-pump strength code
	output logic drive_strength_high, // high output drive strength
	output logic freq_source_select, // register frequency source
	output logic master_spread_enable, // modulation permitted
	output logic [1:0] spread_depth, // spread depth code
	output logic [7:0] grp_zero_spread, // spread per output, applied
	output logic [6:0] grp_mixed_spread, // g1 out0-3, g2 out0-1, g3
	output logic [7:0] grp_zero_freq // 1 = 66 MHz, bit 7 = output zero
);

	// ==================================================
	// input sampling
	logic scl_s, sda_s, strap_s, bnd_s;
	logic scl_d_reg, sda_d_reg, bnd_d_reg;

	// scl and sda idle high, strap and boundary idle low
	cor_sync #(.WIDTH(4), .RESET_VAL(4'hC)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in({scl, sda_in, group_freq_strap, spread_boundary}),
		.sync_out({scl_s, sda_s, strap_s, bnd_s})
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			bnd_d_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			bnd_d_reg <= bnd_s;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det, boundary;
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign boundary = bnd_s & ~bnd_d_reg;

	// ==================================================
	// register storage
	logic [7:0] oe_a_reg, oe_b_reg, mode_reg, ss_a_reg, ss_b_reg, fs_a_reg;
	logic wr_stb_reg;
	logic [6:0] wr_addr_reg;
	logic [7:0] wr_data_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			oe_a_reg <= `COR_RST_OUTPUT_ENABLE_A; // RL1
			oe_b_reg <= `COR_RST_OUTPUT_ENABLE_B; // RL2
			mode_reg <= `COR_RST_SPREAD_MODE_CONTROL; // RL4 RL6 RL9
			ss_a_reg <= `COR_RST_SPREAD_SELECT_A; // RL12
			ss_b_reg <= `COR_RST_SPREAD_SELECT_B; // RL13
			fs_a_reg <= `COR_RST_FREQUENCY_SELECT_A; // RL15
		end else if (wr_stb_reg) begin
			case (wr_addr_reg) // RL18
				`COR_OFS_OUTPUT_ENABLE_A: oe_a_reg <= wr_data_reg;
				`COR_OFS_OUTPUT_ENABLE_B: oe_b_reg <= wr_data_reg;
				`COR_OFS_SPREAD_MODE_CONTROL: mode_reg <= wr_data_reg;
				`COR_OFS_SPREAD_SELECT_A: ss_a_reg <= wr_data_reg;
				`COR_OFS_SPREAD_SELECT_B: ss_b_reg <= wr_data_reg;
				`COR_OFS_FREQUENCY_SELECT_A: fs_a_reg <= wr_data_reg;
				default: ;
			endcase
		end
	end

	function automatic logic [7:0] read_byte(input logic [6:0] ofs);
		case (ofs) // RL18
			`COR_OFS_OUTPUT_ENABLE_A: read_byte = oe_a_reg;
			`COR_OFS_OUTPUT_ENABLE_B: read_byte = oe_b_reg;
			`COR_OFS_SPREAD_MODE_CONTROL: read_byte = mode_reg;
			`COR_OFS_SPREAD_SELECT_A: read_byte = ss_a_reg;
			`COR_OFS_SPREAD_SELECT_B: read_byte = ss_b_reg;
			`COR_OFS_FREQUENCY_SELECT_A: read_byte = fs_a_reg;
			default: read_byte = 8'h00;
		endcase
	endfunction

	// ==================================================
	// field decode
	always_ff @(posedge mclk) begin
		if (reset) begin
			grp_zero_oe <= `COR_RST_OUTPUT_ENABLE_A;
			grp_mixed_oe <= `COR_RST_OUTPUT_ENABLE_B;
			test_output_mode <= 1'b0;
			powerdown_reset_mode <= 1'b0;
			pump_setting <= 2'h0;
			drive_strength_high <= 1'b0;
			freq_source_select <= 1'b0;
			spread_depth <= 2'h0;
			grp_zero_freq <= 8'h00;
		end else begin
			grp_zero_oe <= oe_a_reg; // RL1 RL3
			grp_mixed_oe <= oe_b_reg; // RL2 RL3
			test_output_mode <= mode_reg[7:6] == `COR_MODE_TEST_OUTPUT; // RL4
			powerdown_reset_mode <= mode_reg[7:6] == `COR_MODE_POWERDOWN_RESET; // RL4
			pump_setting <= {mode_reg[`COR_BIT_PUMP_SETTING_HIGH],
				ss_b_reg[`COR_BIT_PUMP_SETTING_LOW]}; // RL5
			drive_strength_high <= mode_reg[`COR_BIT_DRIVE_STRENGTH]; // RL6
			freq_source_select <= mode_reg[`COR_BIT_FREQ_SOURCE_SELECT]; // RL7
			spread_depth <= mode_reg[`COR_BIT_SPREAD_DEPTH_HIGH:`COR_BIT_SPREAD_DEPTH_LOW]; // RL10
			// strap drives every group-zero output unless software owns frequency
			grp_zero_freq <= mode_reg[`COR_BIT_FREQ_SOURCE_SELECT] ? fs_a_reg : {8{strap_s}}; // RL7 RL15
		end
	end

	// spread select and master enable changes reach the clock path only at a safe edge
	localparam logic [7:0] SS_B_RST = `COR_RST_SPREAD_SELECT_B;
	localparam logic [7:0] MODE_RST = `COR_RST_SPREAD_MODE_CONTROL;
	cor_hold #(
		.WIDTH(16),
		.RESET_VAL({`COR_RST_SPREAD_SELECT_A, SS_B_RST[7:1], MODE_RST[`COR_BIT_MASTER_SPREAD_ENABLE]})
	) u_hold (
		.mclk(mclk),
		.reset(reset),
		.boundary(boundary),
		.staged({ss_a_reg, ss_b_reg[7:1], mode_reg[`COR_BIT_MASTER_SPREAD_ENABLE]}), // RL9 RL12 RL13 RL14
		.applied({grp_zero_spread, grp_mixed_spread, master_spread_enable}) // RL11
	);

	// ==================================================
	// serial slave
	cor_pkg::cor_state_type state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg, tx_reg, remain_reg, pend_data_reg;
	logic [6:0] ptr_reg;
	logic block_reg, send_count_reg, pend_wr_reg;
	logic [7:0] cur_byte, next_byte;

	// bytes at and after the pointer, ready for the next read slot
	always_comb begin
		cur_byte = read_byte(ptr_reg);
		next_byte = read_byte(ptr_reg + 7'h01);
	end

	assign sda_out = 1'b0;

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= cor_pkg::cor_st_idle;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			remain_reg <= 8'h00;
			pend_data_reg <= 8'h00;
			ptr_reg <= 7'h00;
			block_reg <= 1'b0;
			send_count_reg <= 1'b0;
			pend_wr_reg <= 1'b0;
			sda_oe <= 1'b0;
			wr_stb_reg <= 1'b0;
			wr_addr_reg <= 7'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_stb_reg <= 1'b0;
			if (start_det) begin
				state_reg <= cor_pkg::cor_st_addr;
				bit_cnt_reg <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_det) begin
				state_reg <= cor_pkg::cor_st_idle;
				sda_oe <= 1'b0;
			end else begin
				case (state_reg)
					cor_pkg::cor_st_addr, cor_pkg::cor_st_cmd, cor_pkg::cor_st_count, cor_pkg::cor_st_wdata: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall && bit_cnt_reg == `COR_BITS_PER_BYTE) begin
							bit_cnt_reg <= 4'h0;
							sda_oe <= 1'b1;
							case (state_reg)
								cor_pkg::cor_st_addr: begin
									if (shift_reg[7:1] == DEV_ADDR) begin
										state_reg <= cor_pkg::cor_st_addr_ack;
										// read direction loads the first byte now
										tx_reg <= send_count_reg ? `COR_NUM_REGS : read_byte(ptr_reg);
									end else begin
										state_reg <= cor_pkg::cor_st_idle;
										sda_oe <= 1'b0;
									end
									block_reg <= block_reg;
								end
								cor_pkg::cor_st_cmd: begin
									if (shift_reg[7]) begin
										block_reg <= 1'b0; // RL16
										send_count_reg <= 1'b0;
										ptr_reg <= shift_reg[6:0]; // RL16
										state_reg <= cor_pkg::cor_st_cmd_ack;
									end else if (shift_reg == `COR_CMD_BLOCK) begin
										block_reg <= 1'b1; // RL17
										send_count_reg <= 1'b1; // RL17
										ptr_reg <= 7'h00; // RL17
										state_reg <= cor_pkg::cor_st_cmd_ack;
									end else begin
										state_reg <= cor_pkg::cor_st_idle;
										sda_oe <= 1'b0;
									end
								end
								cor_pkg::cor_st_count: begin
									remain_reg <= shift_reg; // RL17
									send_count_reg <= 1'b0;
									state_reg <= cor_pkg::cor_st_count_ack;
								end
								default: begin
									if (!block_reg || remain_reg != 8'h00) begin
										pend_wr_reg <= 1'b1;
										pend_data_reg <= shift_reg;
										state_reg <= cor_pkg::cor_st_wdata_ack;
									end else begin
										state_reg <= cor_pkg::cor_st_idle;
										sda_oe <= 1'b0;
									end
								end
							endcase
						end
					end
					cor_pkg::cor_st_addr_ack: begin
						if (scl_fall) begin
							if (shift_reg[0]) begin
								state_reg <= cor_pkg::cor_st_rdata;
								sda_oe <= ~tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'b0};
								bit_cnt_reg <= 4'h1;
							end else begin
								state_reg <= cor_pkg::cor_st_cmd;
								sda_oe <= 1'b0;
							end
						end
					end
					cor_pkg::cor_st_cmd_ack, cor_pkg::cor_st_count_ack: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							state_reg <= (state_reg == cor_pkg::cor_st_cmd_ack && block_reg) ?
								cor_pkg::cor_st_count : cor_pkg::cor_st_wdata;
						end
					end
					cor_pkg::cor_st_wdata_ack: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							state_reg <= cor_pkg::cor_st_wdata;
							// commit only once the acknowledge slot is over
							if (pend_wr_reg) begin
								wr_stb_reg <= 1'b1; // RL19
								wr_addr_reg <= ptr_reg;
								wr_data_reg <= pend_data_reg;
								ptr_reg <= ptr_reg + 7'h01;
								remain_reg <= block_reg ? remain_reg - 8'h01 : remain_reg;
								pend_wr_reg <= 1'b0;
							end
						end
					end
					cor_pkg::cor_st_rdata: begin
						if (scl_fall) begin
							if (bit_cnt_reg == `COR_BITS_PER_BYTE) begin
								sda_oe <= 1'b0;
								bit_cnt_reg <= 4'h0;
								state_reg <= cor_pkg::cor_st_rdata_ack;
							end else begin
								sda_oe <= ~tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					cor_pkg::cor_st_rdata_ack: begin
						if (scl_rise && sda_s) begin
							state_reg <= cor_pkg::cor_st_idle;
						end else if (scl_fall) begin
							// the count byte does not advance the offset
							if (send_count_reg) begin
								send_count_reg <= 1'b0;
								tx_reg <= {cur_byte[6:0], 1'b0};
								sda_oe <= ~cur_byte[7];
							end else begin
								ptr_reg <= ptr_reg + 7'h01;
								tx_reg <= {next_byte[6:0], 1'b0};
								sda_oe <= ~next_byte[7];
							end
							bit_cnt_reg <= 4'h1;
							state_reg <= cor_pkg::cor_st_rdata;
						end
					end
					default: ;
				endcase
			end
		end
	end

endmodule

// File: cor_regs_monitor.sv
/*
 * Checker for the clock output control register bank.
 * Assumes it is bound to cor_regs and sees only its ports.
 */
`timescale 1ns/1ps

module cor_regs_monitor (
	input wire logic mclk, // clock
	input wire logic reset, // sync reset
	input wire logic scl, // serial clock
	input wire logic sda_in, // serial data
	input wire logic sda_out, // drive value
	input wire logic sda_oe, // pulls sda low
	input wire logic group_freq_strap, // strap
	input wire logic spread_boundary, // safe edge
	input wire logic [7:0] grp_zero_oe, // enables
	input wire logic [7:0] grp_mixed_oe, // enables
	input wire logic test_output_mode, // mode
	input wire logic powerdown_reset_mode, // mode
	input wire logic [1:0] pump_setting, // pump
	input wire logic drive_strength_high, // strength
	input wire logic freq_source_select, // source
	input wire logic master_spread_enable, // spread on
	input wire logic [1:0] spread_depth, // depth
	input wire logic [7:0] grp_zero_spread, // spread
	input wire logic [6:0] grp_mixed_spread, // spread
	input wire logic [7:0] grp_zero_freq // frequency
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);

	// ====
	// power-up and decode
	reset_values_a: assert property (
		$fell(reset) |-> {grp_zero_oe, grp_mixed_oe, master_spread_enable, grp_zero_spread,
		grp_mixed_spread, grp_zero_freq} == {16'hFFFF, 1'b1, 23'h0}) else $error("power-up value wrong");
	mode_exclusive_a: assert property (
		!(test_output_mode && powerdown_reset_mode)) else $error("two modes at once");
	strap_freq_a: assert property (
		(!freq_source_select && $stable(group_freq_strap)) [*8] |-> grp_zero_freq == {8{group_freq_strap}})
		else $error("strap not followed");

	// ====
	// serial pin
	open_drain_a: assert property (
		sda_out == 1'b0) else $error("sda driven high");
	drive_rise_a: assert property (
		$rose(sda_oe) |-> !scl) else $error("sda pulled while scl high");
	drive_fall_a: assert property (
		$fell(sda_oe) |-> !scl) else $error("sda released while scl high");

	// ====
	// spread select and master enable change only just after a safe edge, so no runt pulse
	zero_spread_a: assert property (
		$changed(grp_zero_spread) |-> spread_boundary && !$past(spread_boundary, 8))
		else $error("group zero spread off boundary");
	mixed_spread_a: assert property (
		$changed(grp_mixed_spread) |-> spread_boundary && !$past(spread_boundary, 8))
		else $error("mixed spread off boundary");
	master_spread_a: assert property (
		$changed(master_spread_enable) |-> spread_boundary && !$past(spread_boundary, 8))
		else $error("master spread off boundary");
endmodule

// File: cor_i2c_master.sv
/*
 * Two-wire bus master model, 48 ns bit period.
 * Assumes sda is resolved outside with a pull-up.
 */
`timescale 1ns/1ps

module cor_i2c_master (
	output logic scl, // serial clock, idle high
	output logic sda_oe_m, // high while pulling sda low
	input wire logic sda // resolved line level
);
	initial begin
		scl = 1'b1;
		sda_oe_m = 1'b0;
	end

	// ====
	// bit level: data bits move only while scl is low; start and stop move sda while scl is high
	// pins move by non-blocking assignment at fixed 12 ns steps, not tied to mclk edges
	task automatic bit_xfer(input logic b, output logic r);
		#12 sda_oe_m <= ~b;
		#12 scl <= 1'b1;
		#12 r = sda;
		#12 scl <= 1'b0;
	endtask

	task automatic start();
		#12 sda_oe_m <= 1'b0;
		#12 scl <= 1'b1;
		#12 sda_oe_m <= 1'b1;
		#12 scl <= 1'b0;
	endtask

	task automatic stop();
		#12 sda_oe_m <= 1'b1;
		#12 scl <= 1'b1;
		#12 sda_oe_m <= 1'b0;
		#12;
	endtask

	// ====
	// byte level, msb first
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
		end
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, d[i]);
		end
		bit_xfer(last, r);
	endtask
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the clock output control register bank.
 * Assumes cor_regs, the master model and the checker are compiled first.
 */
`timescale 1ns/1ps
`include "cor_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end

module tb_top;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic group_freq_strap = 1'b0;
	logic spread_boundary = 1'b0;
	logic scl, m_oe, sda_out, sda_oe, test_output_mode, powerdown_reset_mode;
	logic drive_strength_high, freq_source_select, master_spread_enable;
	logic [1:0] pump_setting, spread_depth;
	logic [7:0] grp_zero_oe, grp_mixed_oe, grp_zero_spread, grp_zero_freq;
	logic [6:0] grp_mixed_spread;
	logic [7:0] rst_val [6] = '{8'hFF, 8'hFF, 8'h04, 8'h00, 8'h00, 8'h00};
	int num_errors = 0;
	int n_checks = 0;
	// pull-up: released line reads high
	wire sda = ~(m_oe | sda_oe);

	always #2 mclk = ~mclk;

	cor_i2c_master u_mst (.scl(scl), .sda_oe_m(m_oe), .sda(sda));
	cor_regs u_dut (.mclk(mclk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.group_freq_strap(group_freq_strap), .spread_boundary(spread_boundary), .grp_zero_oe(grp_zero_oe),
		.grp_mixed_oe(grp_mixed_oe), .test_output_mode(test_output_mode),
		.powerdown_reset_mode(powerdown_reset_mode), .pump_setting(pump_setting),
		.drive_strength_high(drive_strength_high), .freq_source_select(freq_source_select),
		.master_spread_enable(master_spread_enable), .spread_depth(spread_depth),
		.grp_zero_spread(grp_zero_spread), .grp_mixed_spread(grp_mixed_spread), .grp_zero_freq(grp_zero_freq));

	// ====
	// bus helpers
	task automatic hdr(input logic [7:0] cmd, input logic rdm);
		logic a;
		u_mst.start();
		u_mst.wbyte({`COR_DEV_ADDR, 1'b0}, a);
		u_mst.wbyte(cmd, a);
		`CHK(a, 1'b1)
		if (rdm) begin
			u_mst.start();
			u_mst.wbyte({`COR_DEV_ADDR, 1'b1}, a);
		end
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		logic a;
		hdr(cmd, 1'b0);
		u_mst.wbyte(d, a);
		u_mst.stop();
		repeat (8) @(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
		hdr(cmd, 1'b1);
		u_mst.rbyte(1'b1, d);
		u_mst.stop();
		repeat (8) @(posedge mclk);
	endtask

	// ====
	// scenarios
	task automatic t_reset();
		logic [7:0] d;
		`CHK({grp_zero_oe, grp_mixed_oe}, 16'hFFFF)
		`CHK({test_output_mode, powerdown_reset_mode, drive_strength_high, master_spread_enable}, 4'h1)
		`CHK({grp_zero_spread, grp_mixed_spread, grp_zero_freq}, 23'h0)
		hdr(`COR_CMD_BLOCK, 1'b1);
		u_mst.rbyte(1'b0, d);
		`CHK(d, 8'h06)
		for (int i = 0; i < 6; i++) begin
			u_mst.rbyte(i == 5, d);
			`CHK(d, rst_val[i])
		end
		u_mst.stop();
	endtask

	task automatic t_bytes();
		logic [7:0] d;
		wr(8'h80, 8'h5A);
		wr(8'h81, 8'hA6);
		`CHK(grp_zero_oe, 8'h5A)
		`CHK(grp_mixed_oe, 8'hA6)
		for (int m = 0; m < 4; m++) begin
			wr(8'h82, {m[1:0], m[0], m[1], 2'b01, m[1:0]});
			`CHK({test_output_mode, powerdown_reset_mode}, {m == 1, m == 2})
			`CHK({drive_strength_high, pump_setting[1], spread_depth, freq_source_select}, {m[1], m[0], m[1:0], 1'b0})
		end
		rd(8'h82, d);
		`CHK(d, 8'hF7)
	endtask

	task automatic t_spread();
		wr(8'h83, 8'hC3);
		wr(8'h84, 8'hAB);
		wr(8'h82, 8'h20);
		`CHK({grp_zero_spread, grp_mixed_spread, master_spread_enable}, 16'h0001)
		`CHK(pump_setting, 2'h3)
		spread_boundary <= 1'b1;
		repeat (12) @(posedge mclk);
		spread_boundary <= 1'b0;
		repeat (12) @(posedge mclk);
		`CHK({grp_zero_spread, grp_mixed_spread, master_spread_enable}, 16'hC3AA)
	endtask

	task automatic t_freq();
		group_freq_strap <= 1'b1;
		// frequency bits go in before the source switch
		wr(8'h85, 8'h3C);
		`CHK(grp_zero_freq, 8'hFF)
		wr(8'h82, 8'h08);
		`CHK(grp_zero_freq, 8'h3C)
		group_freq_strap <= 1'b0;
		wr(8'h82, 8'h00);
		`CHK(grp_zero_freq, 8'h00)
	endtask

	task automatic t_refuse();
		logic [7:0] d;
		logic a;
		wr(8'h86, 8'h77);
		rd(8'h86, d);
		`CHK(d, 8'h00)
		u_mst.start();
		u_mst.wbyte({7'h12, 1'b0}, a);
		`CHK(a, 1'b0)
		u_mst.stop();
		u_mst.start();
		u_mst.wbyte({`COR_DEV_ADDR, 1'b0}, a);
		u_mst.wbyte(8'h40, a);
		`CHK(a, 1'b0)
		u_mst.stop();
		hdr(`COR_CMD_BLOCK, 1'b0);
		u_mst.wbyte(8'h02, a);
		u_mst.wbyte(8'h11, a);
		u_mst.wbyte(8'h22, a);
		u_mst.wbyte(8'h33, a);
		`CHK(a, 1'b0)
		u_mst.stop();
		rd(8'h81, d);
		`CHK({grp_zero_oe, d}, 16'h1122)
	endtask

	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		repeat (8) @(posedge mclk);
		t_reset();
		t_bytes();
		t_spread();
		t_freq();
		t_refuse();
		finish_test();
	end

	// whole run is about 33 us; a hang stops here
	initial begin
		#300000;
		num_errors++;
		finish_test();
	end
endmodule

bind cor_regs cor_regs_monitor u_mon (.mclk(mclk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .group_freq_strap(group_freq_strap), .spread_boundary(spread_boundary),
	.grp_zero_oe(grp_zero_oe), .grp_mixed_oe(grp_mixed_oe), .test_output_mode(test_output_mode),
	.powerdown_reset_mode(powerdown_reset_mode), .pump_setting(pump_setting),
	.drive_strength_high(drive_strength_high), .freq_source_select(freq_source_select),
	.master_spread_enable(master_spread_enable), .spread_depth(spread_depth),
	.grp_zero_spread(grp_zero_spread), .grp_mixed_spread(grp_mixed_spread), .grp_zero_freq(grp_zero_freq));
